/* File: hdl/rtm_params.svh */
// Register map, field positions, reset values and divisors of the timers
// Operation
// - Timer zero is a 16-bit down-counter fed through a prescaler.
// - Timer zero prescale bits 3:2 divide by 1, 16, 256; code 11 as 00.
// - Timer zero source bits 5:4: core, secondary clock, slow oscillator.
// - Timer zero control bit 7 enables counting; clear after reset.
// - Timer zero control bit 6 selects periodic reload, else free-running.
// - Timer zero has a 16-bit read/write load register.
// - Timer zero live count is read-only and resets to all ones.
// - Any write to timer zero clear register drops its interrupt unless a hit falls in that cycle.
// - Each timer drives a trigger output usable to start conversions.
// - Timer one is 32-bit; control bit 8 counts up, clear counts down.
// - Timer one control bit 7 enables counting; disabled after reset.
// - Timer one control bit 6 selects periodic reload, else free-running.
// - Timer one source bits 11:9: core, crystal, secondary, pin edges.
// - Timer one prescale bits 3:0 divide by 1, 16, 256, 32768.
// - Timer one format bits 5:4: binary, or time of day wrapping 23/255.
// - With control bit 17 set, first selected event copies count to capture.
// - Capture event bits 16:12 select one of 32 interrupt sources.
// - Timer one has a 32-bit read/write load register.
// - Timer one live 32-bit count is a read-only register.
// - Periodic restarts from load at end of range; free-running wraps.
// - Interrupt raised when count reaches zero down or full scale up.
// - Time of day: hours 31:24, minutes 21:16, seconds 13:8, ticks 6:0.
// - Any write to timer one clear register drops its interrupt unless a hit falls in that cycle.
`ifndef RTM_PARAMS_SVH
`define RTM_PARAMS_SVH

`define RTM_T0_LOAD_ADDR 32'hFFFF0300
`define RTM_T0_COUNT_ADDR 32'hFFFF0304
`define RTM_T0_CTRL_ADDR 32'hFFFF0308
`define RTM_T0_CLR_ADDR 32'hFFFF030C
`define RTM_T1_LOAD_ADDR 32'hFFFF0320
`define RTM_T1_COUNT_ADDR 32'hFFFF0324
`define RTM_T1_CTRL_ADDR 32'hFFFF0328
`define RTM_T1_CLR_ADDR 32'hFFFF032C
`define RTM_T1_CAP_ADDR 32'hFFFF0330

`define RTM_T0_LOAD_RST 16'h0000
`define RTM_T0_COUNT_RST 16'hFFFF
`define RTM_T0_CTRL_RST 16'h0000
`define RTM_T0_CTRL_MASK 16'h00FC
`define RTM_T1_LOAD_RST 32'h00000000
`define RTM_T1_COUNT_RST 32'h0FFFFFFF
`define RTM_T1_CTRL_RST 32'h00000000
`define RTM_T1_CTRL_MASK 32'h0003FFFF
`define RTM_T1_CAP_RST 32'h00000000

// Prescale codes and divide ratios
`define RTM_T0_PS_16 2'h1
`define RTM_T0_PS_256 2'h2
`define RTM_T1_PS_16 4'h4
`define RTM_T1_PS_256 4'h8
`define RTM_T1_PS_32K 4'hF
`define RTM_DIV_16 15'h000F
`define RTM_DIV_256 15'h00FF
`define RTM_DIV_32K 15'h7FFF

// Time of day field limits
`define RTM_TOD_TICK_MAX 7'h7F
`define RTM_TOD_MS_MAX 6'h3B
`define RTM_TOD_HR_24 8'h17
`define RTM_TOD_HR_256 8'hFF

// Highest external pin rate the far side may apply, in MHz
`define RTM_EXT_PIN_MAX_MHZ 44

`endif

/* File: hdl/rtm_pkg.sv */
// Types shared by the timer block
package rtm_pkg;

    typedef struct packed {
        logic [7:0] rsvd_hi;
        logic enable;
        logic periodic;
        logic [1:0] clk_sel;
        logic [1:0] prescale;
        logic [1:0] rsvd_lo;
    } rtm_t0_ctrl_t;

    typedef struct packed {
        logic [13:0] rsvd;
        logic cap_en;
        logic [4:0] cap_event;
        logic [2:0] clk_sel;
        logic count_up;
        logic enable;
        logic periodic;
        logic [1:0] format;
        logic [3:0] prescale;
    } rtm_t1_ctrl_t;

    // Interrupt level and conversion trigger pulse of one timer
    typedef struct packed {
        logic irq;
        logic adc_trig;
    } rtm_evt_t;

    typedef enum logic [1:0] {
        RTM_FMT_BIN,
        RTM_FMT_RSVD,
        RTM_FMT_TOD24,
        RTM_FMT_TOD256
    } rtm_fmt_t;

endpackage : rtm_pkg

/* File: hdl/rtm_timers.sv */
// Two programmable timers with capture, behind an APB slave
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`include "rtm_params.svh"
module rtm_timers
    import rtm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic secondary_system_clock,
    input wire logic low_freq_osc,
    input wire logic crystal_clock,
    input wire logic external_count_pin,
    input wire logic [31:0] irq_sources,
    output rtm_evt_t rtos_evt,
    output rtm_evt_t gp_evt
);

    logic rst_meta_n;
    logic rst_n;
    rtm_t0_ctrl_t rtos_timer_control;
    rtm_t1_ctrl_t gp_timer_control;
    logic [15:0] rtos_timer_load;
    logic [15:0] rtos_timer_count;
    logic [31:0] gp_timer_load;
    logic [31:0] gp_timer_count;
    logic [31:0] gp_timer_capture;
    logic [3:0] src_prev;
    logic [3:0] src_rise;
    logic [7:0] t0_pre;
    logic [14:0] t1_pre;
    logic [14:0] t1_div;
    logic [7:0] t0_div;
    logic t0_src;
    logic t1_src;
    logic t0_tick;
    logic t1_tick;
    logic [15:0] next_t0;
    logic [31:0] next_t1;
    logic [31:0] t1_full;
    logic [31:0] t1_end;
    logic [7:0] hr_max;
    logic t1_tod;
    logic t0_hit;
    logic t1_hit;
    logic t0_start;
    logic t1_start;
    logic wr_acc;
    logic setup;
    logic evt_prev;
    logic cap_done;
    logic evt_sel;

    // Reset released through two flops so release is glitch free
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // No wait states: read data is latched in setup, answered in access
    assign setup = psel && !penable;
    assign pready = psel && penable;
    assign wr_acc = psel && penable && pwrite;
    assign t0_start = wr_acc && paddr == `RTM_T0_CTRL_ADDR
                      && pwdata[7] && !rtos_timer_control.enable;
    assign t1_start = wr_acc && paddr == `RTM_T1_CTRL_ADDR
                      && pwdata[7] && !gp_timer_control.enable;

    // Register writes take effect on the access edge only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rtos_timer_control <= rtm_t0_ctrl_t'(`RTM_T0_CTRL_RST);
            rtos_timer_load <= `RTM_T0_LOAD_RST;
            gp_timer_control <= rtm_t1_ctrl_t'(`RTM_T1_CTRL_RST);
            gp_timer_load <= `RTM_T1_LOAD_RST;
        end else if (wr_acc) begin
            case (paddr)
                `RTM_T0_LOAD_ADDR: rtos_timer_load <= pwdata[15:0];
                `RTM_T0_CTRL_ADDR: rtos_timer_control <=
                    rtm_t0_ctrl_t'(pwdata[15:0] & `RTM_T0_CTRL_MASK);
                `RTM_T1_LOAD_ADDR: gp_timer_load <= pwdata;
                `RTM_T1_CTRL_ADDR: gp_timer_control <=
                    rtm_t1_ctrl_t'(pwdata & `RTM_T1_CTRL_MASK);
                default: ;
            endcase
        end
    end

    // Read mux and error flag, captured in the setup cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            case (paddr)
                `RTM_T0_LOAD_ADDR: prdata <= {16'h0000, rtos_timer_load};
                `RTM_T0_COUNT_ADDR: prdata <= {16'h0000, rtos_timer_count};
                `RTM_T0_CTRL_ADDR: prdata <= {16'h0000, rtos_timer_control};
                `RTM_T1_LOAD_ADDR: prdata <= gp_timer_load;
                // Count lives in the bus clock, so a read never tears
                `RTM_T1_COUNT_ADDR: prdata <= gp_timer_count;
                `RTM_T1_CTRL_ADDR: prdata <= gp_timer_control;
                `RTM_T1_CAP_ADDR: prdata <= gp_timer_capture;
                `RTM_T0_CLR_ADDR, `RTM_T1_CLR_ADDR: ;
                default: pslverr <= 1'b1;
            endcase
        end
    end

    // Source edges; inputs are already in the core clock domain
    assign src_rise = {external_count_pin, crystal_clock, low_freq_osc,
                       secondary_system_clock} & ~src_prev;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_prev <= 4'h0;
        end else begin
            src_prev <= {external_count_pin, crystal_clock, low_freq_osc,
                         secondary_system_clock};
        end
    end

    // Source and divider selection; reserved source codes never tick
    always_comb begin
        case (rtos_timer_control.clk_sel)
            2'h0: t0_src = 1'b1;
            2'h1: t0_src = src_rise[0];
            2'h2: t0_src = src_rise[1];
            default: t0_src = 1'b0;
        endcase
        case (rtos_timer_control.prescale)
            `RTM_T0_PS_16: t0_div = 8'(`RTM_DIV_16);
            `RTM_T0_PS_256: t0_div = 8'(`RTM_DIV_256);
            default: t0_div = 8'h00;
        endcase
        case (gp_timer_control.clk_sel)
            3'h0: t1_src = 1'b1;
            3'h1: t1_src = src_rise[2];
            3'h2: t1_src = src_rise[0];
            3'h3: t1_src = src_rise[3];
            default: t1_src = 1'b0;
        endcase
        case (gp_timer_control.prescale)
            `RTM_T1_PS_16: t1_div = `RTM_DIV_16;
            `RTM_T1_PS_256: t1_div = `RTM_DIV_256;
            `RTM_T1_PS_32K: t1_div = `RTM_DIV_32K;
            default: t1_div = 15'h0000;
        endcase
    end

    // Prescalers restart when their timer is stopped
    assign t0_tick = rtos_timer_control.enable && t0_src && t0_pre == t0_div;
    assign t1_tick = gp_timer_control.enable && t1_src && t1_pre == t1_div;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            t0_pre <= 8'h00;
            t1_pre <= 15'h0000;
        end else begin
            if (!rtos_timer_control.enable || t0_tick) begin
                t0_pre <= 8'h00;
            end else if (t0_src) begin
                t0_pre <= 8'(t0_pre + 8'h01);
            end
            if (!gp_timer_control.enable || t1_tick) begin
                t1_pre <= 15'h0000;
            end else if (t1_src) begin
                t1_pre <= 15'(t1_pre + 15'h0001);
            end
        end
    end

    // One time-of-day step with carries or borrows across fields
    function automatic logic [31:0] tod_step(input logic [31:0] v,
                                             input logic up,
                                             input logic [7:0] hmax);
        logic [7:0] h;
        logic [5:0] m;
        logic [5:0] s;
        logic [6:0] t;
        h = v[31:24];
        m = v[21:16];
        s = v[13:8];
        t = v[6:0];
        if (up) begin
            if (t != `RTM_TOD_TICK_MAX) begin
                t = 7'(t + 7'h01);
            end else begin
                t = 7'h00;
                if (s != `RTM_TOD_MS_MAX) begin
                    s = 6'(s + 6'h01);
                end else begin
                    s = 6'h00;
                    if (m != `RTM_TOD_MS_MAX) begin
                        m = 6'(m + 6'h01);
                    end else begin
                        m = 6'h00;
                        h = (h == hmax) ? 8'h00 : 8'(h + 8'h01);
                    end
                end
            end
        end else begin
            if (t != 7'h00) begin
                t = 7'(t - 7'h01);
            end else begin
                t = `RTM_TOD_TICK_MAX;
                if (s != 6'h00) begin
                    s = 6'(s - 6'h01);
                end else begin
                    s = `RTM_TOD_MS_MAX;
                    if (m != 6'h00) begin
                        m = 6'(m - 6'h01);
                    end else begin
                        m = `RTM_TOD_MS_MAX;
                        h = (h == 8'h00) ? hmax : 8'(h - 8'h01);
                    end
                end
            end
        end
        // Gaps between fields always read zero
        return {h, 2'h0, m, 2'h0, s, 1'b0, t};
    endfunction : tod_step

    // Time of day only for codes 10 and 11; reserved 01 counts binary
    assign t1_tod = gp_timer_control.format[1];
    assign hr_max = (gp_timer_control.format == RTM_FMT_TOD24) ?
                    `RTM_TOD_HR_24 : `RTM_TOD_HR_256;
    assign t1_full = t1_tod ? {hr_max, 2'h0, `RTM_TOD_MS_MAX, 2'h0,
                     `RTM_TOD_MS_MAX, 1'b0, `RTM_TOD_TICK_MAX} : 32'hFFFFFFFF;
    assign t1_end = gp_timer_control.count_up ? t1_full : 32'h00000000;

    // Next counts: periodic reloads past the end, free-running wraps
    always_comb begin
        if (rtos_timer_control.periodic && rtos_timer_count == 16'h0000) begin
            next_t0 = rtos_timer_load;
        end else begin
            next_t0 = 16'(rtos_timer_count - 16'h0001);
        end
        if (gp_timer_control.periodic && gp_timer_count == t1_end) begin
            next_t1 = gp_timer_load;
        end else if (t1_tod) begin
            next_t1 = tod_step(gp_timer_count, gp_timer_control.count_up,
                               hr_max);
        end else if (gp_timer_control.count_up) begin
            next_t1 = 32'(gp_timer_count + 32'h00000001);
        end else begin
            next_t1 = 32'(gp_timer_count - 32'h00000001);
        end
    end

    assign t0_hit = t0_tick && next_t0 == 16'h0000;
    assign t1_hit = t1_tick && next_t1 == t1_end;

    // Counters; a fresh enable restarts from the load value
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rtos_timer_count <= `RTM_T0_COUNT_RST;
            gp_timer_count <= `RTM_T1_COUNT_RST;
        end else begin
            if (t0_start) begin
                rtos_timer_count <= rtos_timer_load;
            end else if (t0_tick) begin
                rtos_timer_count <= next_t0;
            end
            if (t1_start) begin
                gp_timer_count <= gp_timer_load;
            end else if (t1_tick) begin
                gp_timer_count <= next_t1;
            end
        end
    end

    // Sticky interrupts: a hit in the clear cycle wins over the clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rtos_evt <= '0;
            gp_evt <= '0;
        end else begin
            rtos_evt.adc_trig <= t0_hit;
            gp_evt.adc_trig <= t1_hit;
            if (t0_hit) begin
                rtos_evt.irq <= 1'b1;
            end else if (wr_acc && paddr == `RTM_T0_CLR_ADDR) begin
                rtos_evt.irq <= 1'b0;
            end
            if (t1_hit) begin
                gp_evt.irq <= 1'b1;
            end else if (wr_acc && paddr == `RTM_T1_CLR_ADDR) begin
                gp_evt.irq <= 1'b0;
            end
        end
    end

    // Capture on the first rising edge of the chosen source, then hold
    assign evt_sel = irq_sources[gp_timer_control.cap_event];
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gp_timer_capture <= `RTM_T1_CAP_RST;
            evt_prev <= 1'b0;
            cap_done <= 1'b0;
        end else begin
            evt_prev <= evt_sel;
            if (!gp_timer_control.cap_en) begin
                cap_done <= 1'b0; // Rearmed by clearing the enable
            end else if (evt_sel && !evt_prev && !cap_done) begin
                gp_timer_capture <= gp_timer_count;
                cap_done <= 1'b1;
            end
        end
    end

    chk_t0_irq_raise: assert property (@(posedge clk_sys)
        disable iff (!rst_n) t0_hit |=> rtos_evt.irq && rtos_evt.adc_trig)
        else $error("timer zero hit did not raise irq and trigger");

    chk_t0_irq_clear: assert property (@(posedge clk_sys)
        disable iff (!rst_n) wr_acc && paddr == `RTM_T0_CLR_ADDR && !t0_hit
        |=> !rtos_evt.irq) else $error("timer zero irq survived clear write");

    chk_t1_irq_clear: assert property (@(posedge clk_sys)
        disable iff (!rst_n) wr_acc && paddr == `RTM_T1_CLR_ADDR && !t1_hit
        |=> !gp_evt.irq) else $error("timer one irq survived clear write");

    chk_t0_stop_hold: assert property (@(posedge clk_sys)
        disable iff (!rst_n) !rtos_timer_control.enable && !t0_start
        |=> $stable(rtos_timer_count)) else $error("stopped count changed");

    chk_t0_div_sixteen: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        rtos_timer_control.enable && rtos_timer_control.clk_sel == 2'h0
        && rtos_timer_control.prescale == `RTM_T0_PS_16 && t0_tick
        && !wr_acc ##1 !wr_acc [*8] |-> $stable(rtos_timer_count))
        else $error("timer zero ticked faster than one in sixteen");

    chk_t0_reload: assert property (@(posedge clk_sys)
        disable iff (!rst_n) t0_tick && rtos_timer_control.periodic
        && !t0_start && rtos_timer_count == 16'h0000
        |=> rtos_timer_count == $past(rtos_timer_load))
        else $error("periodic timer zero did not reload");

    chk_t1_up_count: assert property (@(posedge clk_sys)
        disable iff (!rst_n) t1_tick && !t1_start && !t1_tod
        && gp_timer_control.count_up && gp_timer_count != t1_end
        |=> gp_timer_count == 32'($past(gp_timer_count) + 32'h00000001))
        else $error("timer one up count wrong");

    chk_t1_capture: assert property (@(posedge clk_sys)
        disable iff (!rst_n) gp_timer_control.cap_en && evt_sel && !evt_prev
        && !cap_done |=> gp_timer_capture == $past(gp_timer_count) && cap_done)
        else $error("capture missed selected event");

    chk_apb_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
        setup |=> pready || !psel)
        else $error("access phase not answered at once");

endmodule : rtm_timers

/* File: verification/rtm_apb_master.sv */
// APB master model standing in for the processor core
`timescale 1ns/1ns
module rtm_apb_master (
    input wire logic clk_sys,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
    end

    // One transfer; idle edge first so a release never meets a new setup
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Request held until pready is seen at a rising edge
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : rtm_apb_master

/* File: verification/test_rtos_and_general_timers.sv */
// Self-checking bench for the two timers
`timescale 1ns/1ns
`include "rtm_params.svh"
module test_rtos_and_general_timers
    import rtm_pkg::*;
;
    logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0] src;
    logic [31:0] irq_src;
    rtm_evt_t rtos_evt, gp_evt;
    int num_errors, checks_done;

    rtm_timers dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .secondary_system_clock(src[0]), .low_freq_osc(src[1]),
        .crystal_clock(src[2]), .external_count_pin(src[3]),
        .irq_sources(irq_src), .rtos_evt(rtos_evt), .gp_evt(gp_evt));

    rtm_apb_master bfm_u (.clk_sys(clk_sys), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // 20 MHz core clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [31:0] a, d);
        bfm_u.xfer(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rdr(input logic [31:0] a);
        bfm_u.xfer(1'b0, a, 32'h0, rd, err);
    endtask : rdr

    function automatic logic irq_of(input logic t1);
        return t1 ? gp_evt.irq : rtos_evt.irq;
    endfunction : irq_of

    function automatic logic trig_of(input logic t1);
        return t1 ? gp_evt.adc_trig : rtos_evt.adc_trig;
    endfunction : trig_of

    // Whole high and low cycles, well under the pin rate limit
    task automatic pulse(input int b);
        @(posedge clk_sys);
        src[b] <= 1'b1;
        @(posedge clk_sys);
        src[b] <= 1'b0;
    endtask : pulse

    task automatic evt_pulse(input int b);
        @(posedge clk_sys);
        irq_src[b] <= 1'b1;
        @(posedge clk_sys);
        irq_src[b] <= 1'b0;
    endtask : evt_pulse

    // Load, clear, stop, start; count core cycles until the interrupt shows
    task automatic run_case(input logic t1, input logic [31:0] ld, ct,
                            input int exp_n);
        int n;
        logic [31:0] base;
        n = 0;
        base = t1 ? `RTM_T1_LOAD_ADDR : `RTM_T0_LOAD_ADDR;
        wr(base, ld);
        // Service order: clear, stop, then restart enabled
        wr(base + 32'hC, 32'h5A);
        wr(base + 32'h8, 32'h0);
        @(negedge clk_sys);
        check("irq after clear", 32'(irq_of(t1)), 32'h0);
        wr(base + 32'h8, ct);
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (irq_of(t1) !== 1'b1 && n < 40000);
        check("cycles to irq", 32'(n), 32'(exp_n));
        check("trigger", 32'(trig_of(t1)), 32'h1);
    endtask : run_case

    task automatic src_count(input logic t1, input logic [31:0] ct, ld,
                             input int b, k, input logic [31:0] exp);
        logic [31:0] base;
        base = t1 ? `RTM_T1_LOAD_ADDR : `RTM_T0_LOAD_ADDR;
        wr(base + 32'h8, 32'h0);
        wr(base, ld);
        wr(base + 32'h8, ct);
        repeat (k) pulse(b);
        repeat (4) @(posedge clk_sys);
        rdr(base + 32'h4);
        check("source count", rd, exp);
    endtask : src_count

    task automatic t_reset_and_refused();
        logic [31:0] a[8] = '{`RTM_T0_LOAD_ADDR, `RTM_T0_COUNT_ADDR,
            `RTM_T0_CTRL_ADDR, `RTM_T1_LOAD_ADDR, `RTM_T1_COUNT_ADDR,
            `RTM_T1_CTRL_ADDR, `RTM_T1_CAP_ADDR, `RTM_T0_CLR_ADDR};
        logic [31:0] e[8] = '{32'h0, 32'h0000FFFF, 32'h0, 32'h0,
            `RTM_T1_COUNT_RST, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 8; i++) begin
            rdr(a[i]);
            check("reset value", rd, e[i]);
        end
        wr(`RTM_T0_COUNT_ADDR, 32'h00001234);
        rdr(`RTM_T0_COUNT_ADDR);
        check("read-only count", rd, 32'h0000FFFF);
        wr(`RTM_T0_CTRL_ADDR, 32'h0000FFFF);
        rdr(`RTM_T0_CTRL_ADDR);
        check("reserved bits", rd, 32'h000000FC);
        wr(`RTM_T1_LOAD_ADDR, 32'hA5C3F00F);
        rdr(`RTM_T1_LOAD_ADDR);
        check("load readback", rd, 32'hA5C3F00F);
        rdr(32'hFFFF0340);
        check("unmapped error", 32'(err), 32'h1);
        $display("test reset_and_refused done");
    endtask : t_reset_and_refused

    task automatic t_prescale();
        logic [31:0] c0[4] = '{32'h80, 32'h84, 32'hC8, 32'h8C};
        int e0[4] = '{2, 32, 512, 2};
        logic [31:0] c1[5] = '{32'h80, 32'h84, 32'h88, 32'h8F, 32'h81};
        int e1[5] = '{1, 16, 256, 32768, 1};
        for (int i = 0; i < 4; i++) run_case(1'b0, 32'h2, c0[i], e0[i]);
        for (int i = 0; i < 5; i++) run_case(1'b1, 32'h1, c1[i], e1[i]);
        run_case(1'b1, 32'hFFFFFFFE, 32'h180, 1);
        $display("test prescale done");
    endtask : t_prescale

    task automatic t_periodic();
        int n;
        n = 0;
        run_case(1'b0, 32'h3, 32'hC0, 3);
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (rtos_evt.adc_trig !== 1'b1 && n < 100);
        check("reload period", 32'(n), 32'h4);
        check("irq held", 32'(rtos_evt.irq), 32'h1);
        $display("test periodic done");
    endtask : t_periodic

    task automatic t_sources();
        src_count(1'b0, 32'h90, 32'hA, 0, 4, 32'h6);
        src_count(1'b0, 32'hA0, 32'hA, 1, 4, 32'h6);
        src_count(1'b0, 32'hB0, 32'hA, 0, 4, 32'hA);
        src_count(1'b1, 32'h280, 32'hA, 2, 4, 32'h6);
        src_count(1'b1, 32'h480, 32'hA, 0, 4, 32'h6);
        src_count(1'b1, 32'h680, 32'hA, 3, 3, 32'h7);
        src_count(1'b1, 32'h7A0, 32'h3B7F, 3, 1, 32'h10000);
        src_count(1'b1, 32'h6A0, 32'h1000000, 3, 1, 32'h3B3B7F);
        src_count(1'b1, 32'h6A0, 32'h0, 3, 1, 32'h173B3B7F);
        src_count(1'b1, 32'h6B0, 32'h0, 3, 1, 32'hFF3B3B7F);
        src_count(1'b1, 32'h680, 32'h0, 3, 1, 32'hFFFFFFFF);
        $display("test sources done");
    endtask : t_sources

    task automatic t_capture();
        wr(`RTM_T1_CTRL_ADDR, 32'h0);
        wr(`RTM_T1_LOAD_ADDR, 32'd100);
        wr(`RTM_T1_CTRL_ADDR, 32'h25680);
        repeat (3) pulse(3);
        evt_pulse(4);
        evt_pulse(5);
        repeat (2) pulse(3);
        evt_pulse(5);
        rdr(`RTM_T1_CAP_ADDR);
        check("capture", rd, 32'd97);
        $display("test capture done");
    endtask : t_capture

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // Longest case is a 32768 divide; the rest is under two thousand cycles
    initial begin
        #5000000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        num_errors = 0;
        checks_done = 0;
        arst_n = 1'b0;
        src = 4'h0;
        irq_src = 32'h00000000;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset_and_refused();
        t_prescale();
        t_periodic();
        t_sources();
        t_capture();
        tally_and_finish();
    end
endmodule : test_rtos_and_general_timers
